// file: rtl/tspl_consts.vh
`ifndef TSPL_CONSTS_VH
`define TSPL_CONSTS_VH

// register map of the parallel processor port
`define TSPL_ADDR_W           9
`define TSPL_ADDR_BIT_OFFSET  9'h0D5
`define TSPL_ADDR_SLOT_OFFSET 9'h0D6

// field layout
`define TSPL_BIT_OFS_MSB      2
`define TSPL_SLOT_OFS_MSB     6
`define TSPL_BIT_OFS_MASK     8'h07
`define TSPL_SLOT_OFS_MASK    8'h7F

// reset values
`define TSPL_BIT_OFS_RST      3'h0
`define TSPL_SLOT_OFS_RST     7'h00

// system bus rate codes
`define TSPL_RATE_1536        3'h0
`define TSPL_RATE_1544        3'h1
`define TSPL_RATE_2048        3'h2
`define TSPL_RATE_4096        3'h3
`define TSPL_RATE_8192        3'h4

// last bit index of one transmit system-bus frame per rate
`define TSPL_LAST_1536        10'h0BF
`define TSPL_LAST_1544        10'h0C0
`define TSPL_LAST_2048        10'h0FF
`define TSPL_LAST_4096        10'h1FF
`define TSPL_LAST_8192        10'h3FF

// frames per multiframe, last index
`define TSPL_MF_LAST          5'h17

`endif

// file: rtl/tspl_edge_sync.v
`timescale 1ns/1ps
module tspl_edge_sync (
	// clock and reset
	input  wire i_clk,
	input  wire i_reset,
	// asynchronous level
	input  wire i_async,
	// synchronised rising edge
	output wire o_rise
);
	reg meta_ff;
	reg sync_ff;
	reg last_ff;

	// meta_ff feeds sync_ff only; the edge is taken between later stages
	always @(posedge i_clk) begin
		if (i_reset) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign o_rise = sync_ff & ~last_ff;
endmodule

// file: rtl/tspl_sync_pulse_locator.v
`timescale 1ns/1ps
`include "tspl_consts.vh"

// Functional notes
// R1: seven-bit slot offset in low register bits picks slots 0 to 127.
// R2: software writes zero offset to align with framing bit or slot zero.
// R3: at 2.048/1.544/1.536 rates the offset is a plain binary slot number.
// R4: at 4.096 low bit picks group A/B; at 8.192 two bits pick A-D.
// R5: offsets beyond the frame timebase give no frame or multiframe pulses.
// R6: software writes zero to the reserved top bit of the slot register.
// R7: three-bit bit offset forms low bits of one ten-bit pulse position.
// R8: bit counter matches position, one-bit frame pulse, multiframe pulse in frame 0.
module tspl_sync_pulse_locator (
	// clock and reset
	input  wire       i_clk,
	input  wire       i_reset,
	// processor register port
	input  wire [8:0] i_reg_addr,
	input  wire       i_reg_wr,
	input  wire       i_reg_rd,
	input  wire [7:0] i_reg_wdata,
	output wire [7:0] o_reg_rdata,
	// configuration
	input  wire [2:0] i_sbus_rate,
	// transmit system bus
	input  wire       i_tx_sbus_clk,
	output wire       o_tx_frame_sync_pulse,
	output wire       o_tx_multiframe_sync_pulse
);
	reg  [2:0] bit_ofs_ff;
	reg  [6:0] slot_ofs_ff;
	reg  [7:0] rdata_ff;
	reg  [9:0] bit_cnt_ff;
	reg  [4:0] frm_cnt_ff;
	reg        fsync_ff;
	reg        msync_ff;

	reg  [2:0] nxt_bit_ofs;
	reg  [6:0] nxt_slot_ofs;
	reg  [7:0] nxt_rdata;
	reg  [9:0] nxt_bit_cnt;
	reg  [4:0] nxt_frm_cnt;
	reg        nxt_fsync;
	reg        nxt_msync;

	wire       sbus_rise;
	wire [9:0] frame_last;
	wire [9:0] position;
	wire       in_range;
	wire       hit;
	wire       frame_end;
	wire       mf_end;
	wire       wr_bit_ofs;
	wire       wr_slot_ofs;

	// unknown rate codes fall back to the 2.048 frame
	function [9:0] frame_last_of;
		input [2:0] rate;
		begin
			case (rate)
				`TSPL_RATE_1536: frame_last_of = `TSPL_LAST_1536;
				`TSPL_RATE_1544: frame_last_of = `TSPL_LAST_1544;
				`TSPL_RATE_2048: frame_last_of = `TSPL_LAST_2048;
				`TSPL_RATE_4096: frame_last_of = `TSPL_LAST_4096;
				`TSPL_RATE_8192: frame_last_of = `TSPL_LAST_8192;
				default:         frame_last_of = `TSPL_LAST_2048;
			endcase
		end
	endfunction

	// address decode, shared by the write and read paths
	function is_bit_ofs_addr;
		input [8:0] addr;
		begin
			is_bit_ofs_addr = (addr == `TSPL_ADDR_BIT_OFFSET);
		end
	endfunction

	function is_slot_ofs_addr;
		input [8:0] addr;
		begin
			is_slot_ofs_addr = (addr == `TSPL_ADDR_SLOT_OFFSET);
		end
	endfunction

	// unmapped addresses and reserved bits read as zero
	function [7:0] read_value;
		input [8:0] addr;
		input [2:0] bit_ofs;
		input [6:0] slot_ofs;
		begin
			if (is_bit_ofs_addr(addr)) begin
				read_value = {5'h00, bit_ofs};
			end else if (is_slot_ofs_addr(addr)) begin
				read_value = {1'b0, slot_ofs};
			end else begin
				read_value = 8'h00;
			end
		end
	endfunction

	// a rate change may leave a counter past its new end; wrap it anyway
	function reached_end;
		input [9:0] count;
		input [9:0] last;
		begin
			reached_end = (count >= last);
		end
	endfunction

	// link clock sampled by i_clk; a rising edge starts each bit period
	tspl_edge_sync u_sbus_edge (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async (i_tx_sbus_clk),
		.o_rise  (sbus_rise)
	);

	assign frame_last  = frame_last_of(i_sbus_rate);
	// slot offset above bit offset: one ten-bit position; in the 4.096 and
	// 8.192 rates the group bits fall out of the same binary position
	assign position    = {slot_ofs_ff, bit_ofs_ff}; // [R7] [R1] [R3] [R4]
	// reserved top bit is not stored, so a stray one there cannot misplace pulses
	assign in_range    = (position <= frame_last); // [R5]
	assign hit         = sbus_rise & in_range & (bit_cnt_ff == position); // [R8]
	assign frame_end   = reached_end(bit_cnt_ff, frame_last);
	assign mf_end      = reached_end({5'h00, frm_cnt_ff}, {5'h00, `TSPL_MF_LAST});
	assign wr_bit_ofs  = i_reg_wr & is_bit_ofs_addr(i_reg_addr);
	assign wr_slot_ofs = i_reg_wr & is_slot_ofs_addr(i_reg_addr);

	// offset registers; a write to any other address is dropped
	always @* begin
		nxt_bit_ofs  = bit_ofs_ff;
		nxt_slot_ofs = slot_ofs_ff;
		if (wr_bit_ofs) begin
			nxt_bit_ofs = i_reg_wdata[`TSPL_BIT_OFS_MSB:0]; // [R7]
		end
		if (wr_slot_ofs) begin
			nxt_slot_ofs = i_reg_wdata[`TSPL_SLOT_OFS_MSB:0]; // [R1] [R6]
		end
	end

	// read data holds until the next read; a write in the same cycle is not seen
	always @* begin
		nxt_rdata = rdata_ff;
		if (i_reg_rd) begin
			nxt_rdata = read_value(i_reg_addr, bit_ofs_ff, slot_ofs_ff);
		end
	end

	// free-running timebase: bit within frame, frame within multiframe
	// the 1.544 frame counts its framing bit as bit 0
	always @* begin
		nxt_bit_cnt = bit_cnt_ff;
		nxt_frm_cnt = frm_cnt_ff;
		if (sbus_rise) begin
			if (frame_end) begin
				nxt_bit_cnt = 10'h000;
				if (mf_end) begin
					nxt_frm_cnt = 5'h00;
				end else begin
					nxt_frm_cnt = frm_cnt_ff + 5'h01;
				end
			end else begin
				nxt_bit_cnt = bit_cnt_ff + 10'h001;
			end
		end
	end

	// pulses last exactly one bit period, rise to rise
	// they move only at a detected rise, so a stopped link clock freezes them
	always @* begin
		nxt_fsync = fsync_ff;
		nxt_msync = msync_ff;
		if (sbus_rise) begin
			nxt_fsync = hit; // [R8] [R5]
			nxt_msync = hit & (frm_cnt_ff == 5'h00); // [R8] [R5]
		end
	end

	// register file
	always @(posedge i_clk) begin
		if (i_reset) begin
			bit_ofs_ff  <= `TSPL_BIT_OFS_RST;
			slot_ofs_ff <= `TSPL_SLOT_OFS_RST;
			rdata_ff    <= 8'h00;
		end else begin
			bit_ofs_ff  <= nxt_bit_ofs;
			slot_ofs_ff <= nxt_slot_ofs;
			rdata_ff    <= nxt_rdata;
		end
	end

	// timebase restarts at bit 0 of frame 0 on reset
	always @(posedge i_clk) begin
		if (i_reset) begin
			bit_cnt_ff <= 10'h000;
			frm_cnt_ff <= 5'h00;
		end else begin
			bit_cnt_ff <= nxt_bit_cnt;
			frm_cnt_ff <= nxt_frm_cnt;
		end
	end

	// pulse flops, so both outputs leave the block registered
	always @(posedge i_clk) begin
		if (i_reset) begin
			fsync_ff <= 1'b0;
			msync_ff <= 1'b0;
		end else begin
			fsync_ff <= nxt_fsync;
			msync_ff <= nxt_msync;
		end
	end

	assign o_reg_rdata                = rdata_ff;
	assign o_tx_frame_sync_pulse      = fsync_ff;
	assign o_tx_multiframe_sync_pulse = msync_ff;
endmodule

// file: tb/tspl_tsb_partner.sv
`timescale 1ns/1ps
module tspl_sbus_partner (
	input  wire  i_en,
	output logic o_sbus_clk = 1'b0
);
	// parked low between runs so every run starts at bit 0
	always #40 o_sbus_clk = i_en & ~o_sbus_clk;
endmodule

// file: tb/tspl_sync_pulse_locator_properties.sv
`timescale 1ns/1ps
module tspl_sync_pulse_locator_properties (
	input wire       i_clk,
	input wire       i_reset,
	input wire [8:0] i_reg_addr,
	input wire       i_reg_wr,
	input wire       i_reg_rd,
	input wire [7:0] i_reg_wdata,
	input wire [7:0] o_reg_rdata,
	input wire [2:0] i_sbus_rate,
	input wire       o_tx_frame_sync_pulse,
	input wire       o_tx_multiframe_sync_pulse
);
	wire       fs = o_tx_frame_sync_pulse;
	wire       ms = o_tx_multiframe_sync_pulse;
	reg  [9:0] pos_ff;
	always @(posedge i_clk)
		if (i_reset) pos_ff <= 10'h000;
		else if (i_reg_wr && i_reg_addr == 9'h0D6) pos_ff[9:3] <= i_reg_wdata[6:0];
		else if (i_reg_wr && i_reg_addr == 9'h0D5) pos_ff[2:0] <= i_reg_wdata[2:0];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	AST_MS_FS: assert property (o_tx_multiframe_sync_pulse |-> fs) else $error("msync alone");
	AST_FS_LEN: assert property ($rose(fs) |-> fs[*5] ##1 fs[*5] ##1 !fs)
		else $error("fsync len");
	AST_OFF: assert property (i_sbus_rate == 0 && pos_ff > 10'h0BF && !fs |=> !fs)
		else $error("pulse off range");
	AST_OFF_MS: assert property (i_sbus_rate == 0 && pos_ff > 10'h0BF && !ms |=> !ms)
		else $error("msync off range");
	AST_RD_TS: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 9'h0D6 |=>
		o_reg_rdata == {1'b0, pos_ff[9:3]}) else $error("slot read");
	AST_RD_BIT: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 9'h0D5 |=>
		o_reg_rdata == {5'h00, pos_ff[2:0]}) else $error("bit read");
	AST_HOLD: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
endmodule

// file: tb/tspl_sync_pulse_locator_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
	$display("Error %s exp %0h got %0h", n, e, s); end end
module tspl_sync_pulse_locator_bench;
	logic i_clk = 0, i_reset = 1, i_reg_wr = 0, i_reg_rd = 0, en = 0;
	logic [8:0] i_reg_addr = 0;
	logic [7:0] i_reg_wdata = 0;
	logic [2:0] i_sbus_rate = 0;
	logic [31:0] seed = 25;
	wire [7:0] o_reg_rdata;
	wire i_tx_sbus_clk, o_tx_frame_sync_pulse, o_tx_multiframe_sync_pulse;
	int failures = 0, check_count = 0, idx, pos, last;
	wire hit = idx % (last + 1) == pos;
	always #4 i_clk = ~i_clk;
	tspl_sync_pulse_locator u_tspl_sync_pulse_locator (
		.i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
		.i_sbus_rate(i_sbus_rate), .i_tx_sbus_clk(i_tx_sbus_clk),
		.o_tx_frame_sync_pulse(o_tx_frame_sync_pulse),
		.o_tx_multiframe_sync_pulse(o_tx_multiframe_sync_pulse));
	tspl_sbus_partner u_tspl_sbus_partner (.i_en(en), .o_sbus_clk(i_tx_sbus_clk));
	function logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ x << 5;
	endfunction
	task automatic acc(logic w, logic [8:0] a, logic [7:0] d);
		@(posedge i_clk) {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
		@(posedge i_clk) {i_reg_wr, i_reg_rd} <= 2'h0;
		@(negedge i_clk) if (!w) `CHK("rdata", d, o_reg_rdata)
	endtask
	task conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// sampled mid-bit, clear of synchroniser latency
	always @(negedge i_tx_sbus_clk) if (en) begin
		`CHK("fsync", hit, o_tx_frame_sync_pulse)
		`CHK("msync", hit && idx / (last + 1) % 24 == 0, o_tx_multiframe_sync_pulse)
		idx++;
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		failures++;
		conclude();
	end
	initial for (int r = 0; r < 7; r++) begin
		seed = xs(seed);
		// the last run uses an undefined rate code, which acts as 2.048
		last = r == 6 ? 255 : r % 5 < 2 ? 191 + r % 5 : (256 << r % 5 - 2) - 1;
		pos = r == 5 ? 1023 : r == 6 ? 0 : seed % (last + 1);
		@(posedge i_clk) {en, i_reset, i_sbus_rate} <= {2'h1, r == 6 ? 3'h5 : 3'(r % 5)};
		repeat (10) @(posedge i_clk);
		i_reset <= 0;
		idx = 0;
		acc(1, 9'h0D6, 8'(pos >> 3));
		acc(1, 9'h0D5, 8'(pos % 8));
		acc(0, 9'h0D6, 8'(pos >> 3));
		acc(0, 9'h0D5, 8'(pos % 8));
		acc(0, 9'h0D7, 8'h00);
		en <= 1;
		repeat (last * 20 + 60) @(posedge i_clk);
		$display("run %0d done", r);
		if (r == 6) conclude();
	end
endmodule
bind tspl_sync_pulse_locator tspl_sync_pulse_locator_properties u_props (.*);
